// ---- swc_pkg.sv ----
// Overview of operation
// [R01] metallic inputs get high current for 20 ms
// [R02] timer disabled keeps current while switch closed
// [R03] re-enabled timer limits high current again
// [R04] metallic bit picks 16 mA or 2 mA
// [R05] analog code selects one of 22 inputs
// [R06] analog mux switches only at frame end
// [R07] analog input reads zero in status frame
// [R08] analog bias: high-z, 2 mA or 16 mA
// [R09] reset leaves every current source tri-stated
// [R10] programmable inputs source or sink by mode
// [R11] battery mode, tri-state off: sink to ground
// [R12] ground mode sources, battery mode sinks
// [R13] tri-stated input keeps comparator, low reads one
// [R14] ground input: tri-state off turns source on
// [R15] per-input mask gates interrupt flag
// [R16] controller programs inputs in normal mode
// [R17] frame: thermal, interrupt, programmable, ground bits
// [R18] over-temperature forces every source to 2 mA
// [R19] closure restarts timer, expiry drops high current
// [R20] staged settings applied together at frame end
`default_nettype none
package swc_pkg;
    localparam int NUM_IN = 22;
    localparam int NUM_SG = 14;
    localparam int NUM_SP = 8;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFF_SP_MODE = 8'h00;
    localparam logic [7:0] OFF_METAL = 8'h04;
    localparam logic [7:0] OFF_TIMER_EN = 8'h08;
    localparam logic [7:0] OFF_TRISTATE = 8'h0C;
    localparam logic [7:0] OFF_WAKE_MASK = 8'h10;
    localparam logic [7:0] OFF_ANALOG = 8'h14;
    localparam logic [7:0] OFF_COMMIT = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_SP_MODE = 8'h00;
    localparam logic [21:0] RST_METAL = 22'h3FFFFF;
    localparam logic [21:0] RST_TIMER_EN = 22'h3FFFFF;
    localparam logic [21:0] RST_TRISTATE = 22'h3FFFFF;
    localparam logic [21:0] RST_WAKE_MASK = 22'h3FFFFF;
    localparam logic [4:0] RST_ANALOG = 5'h00;
    // ************************************************************
    // timing
    // ************************************************************
    localparam longint unsigned CLK_HZ = 125_000_000;
    localparam longint unsigned WET_TIME_MS = 20;
    localparam longint unsigned WET_CYC = CLK_HZ * WET_TIME_MS / 1000;
    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0] gnd;
        logic [21:0] met;
        logic [21:0] ten;
        logic [21:0] tri_st;
        logic [21:0] msk;
        logic [4:0] ana;
    } swc_cfg_t;
    typedef struct packed {
        logic [21:0] src;
        logic [21:0] sink;
        logic [21:0] hi;
    } swc_drive_t;
endpackage
`default_nettype wire

// ---- swc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module swc_ctrl #(
    parameter int unsigned WET_CYCLES = int'(swc_pkg::WET_CYC),
    parameter int CW = 22
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [21:0] sw_level,
    input wire logic over_temp,
    output swc_pkg::swc_drive_t drive,
    output logic [4:0] analog_mux_sel,
    output logic analog_mux_en
);
    typedef struct packed {
        swc_pkg::swc_cfg_t stg;
        swc_pkg::swc_cfg_t act;
        swc_pkg::swc_drive_t drv;
        logic [21:0][CW-1:0] cnt;
        logic [21:0] prev;
        logic therm;
        logic intf;
        logic ap_wr;
        logic [7:0] ap_addr;
        logic [31:0] rdata;
        logic rdy;
        logic [4:0] mux_sel;
        logic mux_en;
    } swc_state_t;

    swc_state_t s;
    swc_state_t next_s;
    logic [21:0] closed;
    logic [21:0] ana_m;
    logic [21:0] nz_v;
    logic [23:0] stat;
    logic addr_ok;
    logic hi_page;
    logic commit;

    // ************************************************************
    // input sensing and status frame
    // ************************************************************
    // comparator stays live whatever the bias; low on a ground input
    // means closed
    assign closed[13:0] = ~sw_level[13:0]; // R13
    assign closed[21:14] = sw_level[21:14] ^ s.act.gnd; // R10
    assign ana_m = s.mux_en ? (22'h1 << s.mux_sel) : 22'h0;
    // thermal, interrupt, programmable 7..0, ground 13..0
    assign stat = {s.therm, s.intf, closed & ~ana_m}; // R17 R07
    assign addr_ok = hsel & hready & htrans[1] & (hsize == swc_pkg::HSIZE_WORD);
    assign hi_page = haddr[31:8] != 24'h0;
    // frame end: staged settings become active together
    assign commit = s.ap_wr & (s.ap_addr == swc_pkg::OFF_COMMIT); // R20

    // timer still running, one bit per input
    genvar g;
    generate
        for (g = 0; g < 22; g++) begin : g_nz
            assign nz_v[g] = s.cnt[g] != '0;
        end
    endgenerate

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_s = s;
        next_s.rdy = 1'b1;
        // bus address phase
        next_s.ap_wr = addr_ok & hwrite & ~hi_page;
        next_s.ap_addr = haddr[7:0];
        if (addr_ok && !hwrite) begin
            case (hi_page ? 8'hFF : haddr[7:0])
                swc_pkg::OFF_SP_MODE: next_s.rdata = {24'h0, s.stg.gnd};
                swc_pkg::OFF_METAL: next_s.rdata = {10'h0, s.stg.met};
                swc_pkg::OFF_TIMER_EN: next_s.rdata = {10'h0, s.stg.ten};
                swc_pkg::OFF_TRISTATE: next_s.rdata = {10'h0, s.stg.tri_st};
                swc_pkg::OFF_WAKE_MASK: next_s.rdata = {10'h0, s.stg.msk};
                swc_pkg::OFF_ANALOG: next_s.rdata = {27'h0, s.stg.ana};
                swc_pkg::OFF_STATUS: next_s.rdata = {8'h0, stat};
                default: next_s.rdata = 32'h0;
            endcase
        end
        // bus data phase: writes land in the staging copy
        if (s.ap_wr) begin
            case (s.ap_addr)
                swc_pkg::OFF_SP_MODE: next_s.stg.gnd = hwdata[7:0];
                swc_pkg::OFF_METAL: next_s.stg.met = hwdata[21:0]; // R04
                swc_pkg::OFF_TIMER_EN: next_s.stg.ten = hwdata[21:0]; // R02 R03
                swc_pkg::OFF_TRISTATE: next_s.stg.tri_st = hwdata[21:0];
                swc_pkg::OFF_WAKE_MASK: next_s.stg.msk = hwdata[21:0];
                swc_pkg::OFF_ANALOG: next_s.stg.ana = hwdata[4:0];
                default: next_s.stg = s.stg;
            endcase
        end
        if (commit) begin
            next_s.act = s.stg; // R20
            // code 1..22 picks input code-1, anything else none
            next_s.mux_en = (s.stg.ana != 5'h0) && (s.stg.ana <= 5'd22); // R05
            next_s.mux_sel = s.stg.ana - 5'h1; // R06
        end
        // thermal flag drops at frame end only once cooled
        next_s.therm = over_temp | (s.therm & ~commit);
        // masked change of state sets the flag; set beats read clear
        if (addr_ok && !hwrite && !hi_page && haddr[7:0] == swc_pkg::OFF_STATUS) begin
            next_s.intf = 1'b0;
        end
        if (|((closed ^ s.prev) & s.act.msk) || over_temp) begin
            next_s.intf = 1'b1; // R15
        end
        next_s.prev = closed;
        // per-input timer and current source drive
        for (int i = 0; i < 22; i++) begin
            if (closed[i] && !s.prev[i]) begin
                next_s.cnt[i] = CW'(WET_CYCLES); // R19
            end else if (nz_v[i]) begin
                next_s.cnt[i] = s.cnt[i] - CW'(1); // R19
            end
            if (ana_m[i]) begin
                // analog bias: high-z, or pull-up at either level
                next_s.drv.src[i] = ~s.act.tri_st[i]; // R08
                next_s.drv.sink[i] = 1'b0;
                next_s.drv.hi[i] = s.act.met[i] & ~s.act.tri_st[i] & ~over_temp;
            end else begin
                if (i >= 14) begin
                    next_s.drv.src[i] = ~s.act.tri_st[i] & s.act.gnd[i-14]; // R12
                    next_s.drv.sink[i] = ~s.act.tri_st[i] & ~s.act.gnd[i-14]; // R11
                end else begin
                    next_s.drv.src[i] = ~s.act.tri_st[i]; // R14
                    next_s.drv.sink[i] = 1'b0;
                end
                // timed window, or whole closure with timer off
                next_s.drv.hi[i] = s.act.met[i] & ~s.act.tri_st[i] & ~over_temp
                    & closed[i] & (nz_v[i] | ~s.act.ten[i]); // R01 R02 R03 R18
            end
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // every source starts tri-stated, loads off
            s <= '0; // R09
            s.stg <= '{swc_pkg::RST_SP_MODE, swc_pkg::RST_METAL,
                swc_pkg::RST_TIMER_EN, swc_pkg::RST_TRISTATE,
                swc_pkg::RST_WAKE_MASK, swc_pkg::RST_ANALOG};
            s.act <= '{swc_pkg::RST_SP_MODE, swc_pkg::RST_METAL,
                swc_pkg::RST_TIMER_EN, swc_pkg::RST_TRISTATE,
                swc_pkg::RST_WAKE_MASK, swc_pkg::RST_ANALOG};
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from flops, except hresp, which is tied low
    assign hrdata = s.rdata;
    assign hreadyout = s.rdy;
    assign hresp = 1'b0;
    assign drive = s.drv;
    assign analog_mux_sel = s.mux_sel;
    assign analog_mux_en = s.mux_en;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_tri_quiet: assert property (((s.drv.src | s.drv.sink) & $past(s.act.tri_st)) == 22'h0) // R09
        else $error("tri-stated input drives current");
    chk_ovt_low: assert property (over_temp |=> s.drv.hi == 22'h0) // R18
        else $error("high current during over-temperature");
    chk_sg_src: assert property (##1 s.drv.src[13:0] == $past(~s.act.tri_st[13:0])) // R14
        else $error("ground input source not following tri-state");
    chk_sp_sink: assert property (##1 s.drv.sink[21:14] == $past(~s.act.tri_st[21:14] & ~s.act.gnd & ~ana_m[21:14])) // R11 R12
        else $error("programmable input sink wrong");
    chk_mux_commit: assert property ($changed(s.mux_sel) |-> $past(commit)) // R06
        else $error("analog mux moved without frame end");
    chk_ana_zero: assert property (s.mux_en |-> (stat[21:0] & ana_m) == 22'h0) // R07
        else $error("analog input status bit not zero");
    chk_wet_win: assert property (##1 (s.drv.hi & $past(s.act.ten & ~nz_v & ~ana_m)) == 22'h0) // R01 R03
        else $error("high current outside timed window");
    chk_wet_load: assert property ((closed[0] && !s.prev[0]) |=> s.cnt[0] == CW'(WET_CYCLES)) // R19
        else $error("timer not restarted on closure");
    // flag may only drop one cycle after a frame end clears it
    chk_therm_flag: assert property (over_temp |=> stat[23] // R17 R18
        ##1 (stat[23] || $past(commit)))
        else $error("thermal flag not held");
    chk_int_set: assert property (((closed[0] ^ s.prev[0]) && s.act.msk[0]) |=> s.intf) // R15
        else $error("interrupt flag not set on change");
    // high current only where the active setting asks for it
    chk_hi_met: assert property ( // R04
        ##1 (s.drv.hi & ~$past(s.act.met)) == 22'h0)
        else $error("high current on a low-current input");
    // outside analog use, a battery-mode programmable input never sources current
    chk_bat_nosrc: assert property ( // R12
        ##1 (s.drv.src[21:14] & $past(~s.act.gnd & ~ana_m[21:14])) == 8'h0)
        else $error("battery-mode input sources current");
    // analog bias is pull-up or high-z, never a sink
    chk_ana_sink: assert property ( // R08
        ##1 (s.drv.sink & $past(ana_m)) == 22'h0)
        else $error("analog input sinks current");
    // an enabled mux always points at one of the inputs
    chk_mux_range: assert property (s.mux_en |-> s.mux_sel <= 5'd21) // R05
        else $error("analog mux selects no input");
    // timer counts down by one while running and not reloaded
    chk_cnt_dec: assert property ( // R19
        (nz_v[0] && !(closed[0] && !s.prev[0]))
        |=> s.cnt[0] == $past(s.cnt[0]) - CW'(1))
        else $error("wetting timer not counting down");
    // outside analog use, high current needs a closed contact
    chk_hi_closed: assert property ( // R01 R02
        ##1 (s.drv.hi & ~$past(closed | ana_m)) == 22'h0)
        else $error("high current on an open contact");
    // thermal flag sets on the next edge after the condition
    chk_therm_set: assert property (over_temp |=> s.therm) // R18
        else $error("thermal flag not set");
    // active settings move only at a frame end
    chk_act_commit: assert property ($changed(s.act) |-> $past(commit)) // R20
        else $error("active settings changed without frame end");

    cov_commit_ana: cover property (commit && s.stg.ana != 5'h0);
    cov_timer_end: cover property (s.cnt[0] == CW'(1) ##1 s.cnt[0] == '0);
    cov_hot: cover property (over_temp ##1 !over_temp ##[1:20] commit);
    // programmable input sourcing current in ground mode
    cov_sp_src: cover property (s.drv.src[14] && s.act.gnd[0]);
endmodule
`default_nettype wire

// ---- swc_switch_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// contact field: a closed contact pulls a ground input low,
// a programmable pin goes high or low by its mode
module swc_switch_model (
    input wire logic [21:0] closed,
    input wire logic [7:0] gnd,
    output logic [21:0] sw_level
);
    // comparator levels seen by the block
    assign sw_level[13:0] = ~closed[13:0];
    assign sw_level[21:14] = closed[21:14] ^ gnd;
endmodule
`default_nettype wire

// ---- test_switch_input_config_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_switch_input_config_control;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q;
    logic hreadyout, hresp, men;
    logic ot = 1'b0;
    logic [21:0] closed = 22'h0;
    logic [21:0] lvl;
    logic [7:0] gm = 8'h00;
    logic [4:0] msel;
    swc_pkg::swc_drive_t drv;
    int miscompares = 0;
    int n_compared = 0;
    swc_ctrl #(.WET_CYCLES(20)) i_swc_ctrl (.hclk(hclk),
        .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(swc_pkg::HSIZE_WORD),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sw_level(lvl),
        .over_temp(ot), .drive(drv), .analog_mux_sel(msel),
        .analog_mux_en(men));
    swc_switch_model i_swc_switch_model (.closed(closed), .gnd(gm),
        .sw_level(lvl));
    // free-running 125 MHz clock
    initial begin
        forever #4 hclk = ~hclk;
    end
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // wide enough for the whole drive bundle plus the mux enable
    task automatic chk(input logic [66:0] s, input logic [66:0] e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("Error at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // bounded wait for hready sampled high at an edge
    task automatic rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            end_of_test();
        end
    endtask
    // single word transfer: address phase, then data phase
    task automatic xf(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        q = hrdata;
    endtask
    // staged write, then the frame end that applies it
    task automatic wc(input logic [7:0] a, input logic [31:0] d);
        xf(1'b1, a, d);
        xf(1'b1, swc_pkg::OFF_COMMIT, 32'h0);
        cyc(2);
    endtask
    task automatic t_reset();
        logic [21:0] rv [6];
        rv = '{swc_pkg::RST_SP_MODE, swc_pkg::RST_METAL,
            swc_pkg::RST_TIMER_EN, swc_pkg::RST_TRISTATE,
            swc_pkg::RST_WAKE_MASK, swc_pkg::RST_ANALOG};
        chk({drv, men}, 67'h0);
        for (int i = 0; i < 6; i++) begin
            xf(1'b0, 8'(4 * i), 32'h0);
            chk(q, rv[i]);
        end
        xf(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
    endtask
    task automatic t_wet();
        wc(swc_pkg::OFF_TRISTATE, 32'h3FFFFE);
        chk(drv.src[0], 1'b1);
        closed[0] <= 1'b1;
        cyc(5);
        chk(drv.hi[0], 1'b1);
        cyc(20);
        chk(drv.hi[0], 1'b0);
        closed[0] <= 1'b0;
        cyc(3);
        closed[0] <= 1'b1;
        cyc(5);
        chk(drv.hi[0], 1'b1);
        wc(swc_pkg::OFF_TIMER_EN, 32'h3FFFFE);
        cyc(30);
        chk(drv.hi[0], 1'b1);
        wc(swc_pkg::OFF_TIMER_EN, 32'h3FFFFF);
        chk(drv.hi[0], 1'b0);
        wc(swc_pkg::OFF_TIMER_EN, 32'h3FFFFE);
        wc(swc_pkg::OFF_METAL, 32'h3FFFFE);
        chk(drv.hi[0], 1'b0);
    endtask
    task automatic t_therm();
        wc(swc_pkg::OFF_METAL, 32'h3FFFFF);
        chk(drv.hi[0], 1'b1);
        ot <= 1'b1;
        cyc(3);
        chk(drv.hi[0], 1'b0);
        xf(1'b0, swc_pkg::OFF_STATUS, 32'h0);
        chk(q[23:22], 2'h3);
        ot <= 1'b0;
        wc(swc_pkg::OFF_COMMIT, 32'h0);
        chk(drv.hi[0], 1'b1);
        xf(1'b0, swc_pkg::OFF_STATUS, 32'h0);
        chk(q[23], 1'b0);
    endtask
    task automatic t_prog();
        wc(swc_pkg::OFF_TRISTATE, 32'h3FBFFE);
        chk({drv.src[14], drv.sink[14]}, 2'b01);
        gm <= 8'h01;
        wc(swc_pkg::OFF_SP_MODE, 32'h1);
        chk({drv.src[14], drv.sink[14]}, 2'b10);
        gm <= 8'h00;
        wc(swc_pkg::OFF_SP_MODE, 32'h0);
        chk({drv.src[14], drv.sink[14]}, 2'b01);
    endtask
    task automatic t_mask();
        wc(swc_pkg::OFF_WAKE_MASK, 32'h0);
        xf(1'b0, swc_pkg::OFF_STATUS, 32'h0);
        closed[1] <= 1'b1;
        cyc(3);
        xf(1'b0, swc_pkg::OFF_STATUS, 32'h0);
        chk(q[22], 1'b0);
        chk(q[1:0], 2'h3);
        wc(swc_pkg::OFF_WAKE_MASK, 32'h3FFFFF);
        closed[2] <= 1'b1;
        cyc(3);
        xf(1'b0, swc_pkg::OFF_STATUS, 32'h0);
        chk(q[22], 1'b1);
    endtask
    task automatic t_analog();
        xf(1'b1, swc_pkg::OFF_ANALOG, 32'h1);
        cyc(2);
        chk(men, 1'b0);
        wc(swc_pkg::OFF_COMMIT, 32'h0);
        chk({men, msel}, {1'b1, 5'h00});
        chk({drv.src[0], drv.sink[0], drv.hi[0]}, 3'b101);
        xf(1'b0, swc_pkg::OFF_STATUS, 32'h0);
        chk(q[2:0], 3'h6);
        wc(swc_pkg::OFF_ANALOG, 32'h16);
        chk({men, msel}, {1'b1, 5'h15});
    endtask
    // reset, then every scenario in turn
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_wet();
        t_therm();
        t_prog();
        t_mask();
        t_analog();
        end_of_test();
    end
endmodule
`default_nettype wire
